// >>> rtl/peak_pkg.sv
// Shared constants and carriers for the peak picker with track and hold
package peak_pkg;
  // Temperature word width and fraction
  localparam int TEMP_W = 24;
  localparam int FRAC_W = 8;
  localparam int CLOCK_HZ = 10_000_000;
  localparam int CLOCK_PERIOD_NS = 100;
  // Slowest and fastest decay, hundredths of a degree per second
  localparam int DECAY_MIN_CDEG = 1;
  localparam int DECAY_MAX_CDEG = 30000;
  // Longest start delay in milliseconds
  localparam int DELAY_MAX_MS = 10000;
  // Sample tick period in microseconds
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = (TICK_US * (CLOCK_HZ / 1000)) / 1000;
  localparam int TICKS_PER_S = 1_000_000 / TICK_US;
  localparam int TICKS_PER_MS = 1000 / TICK_US;
  // Upstream response time bounds, kept for the filter setting range
  localparam int RESP_MIN_MS = 10;
  localparam int RESP_MAX_MS = 60000;
  localparam int RESP_W = 16;
  // Wishbone map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DECAY = 8'h04;
  localparam logic [7:0] ADDR_THRESH = 8'h08;
  localparam logic [7:0] ADDR_DELAY = 8'h0C;
  localparam logic [7:0] ADDR_RESP = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_PEAK = 8'h18;
  localparam logic [7:0] ADDR_OUT = 8'h1C;
  // Control bits
  localparam int CTRL_PEAK_EN = 0;
  localparam int CTRL_AUTO_EN = 1;
  localparam int CTRL_DELAY_EN = 2;
  localparam int CTRL_HOLD_EN = 3;
  localparam int CTRL_RESET = 4;
  localparam logic [31:0] CTRL_RST_VAL = 32'h00000000;
  localparam logic [31:0] DECAY_RST_VAL = 32'h00000064;
  localparam logic [31:0] THRESH_RST_VAL = 32'h00000000;
  localparam logic [31:0] DELAY_RST_VAL = 32'h00000000;
  localparam logic [31:0] RESP_RST_VAL = 32'h0000000A;
  // Reset contact: closure shorter than this is a momentary reset pulse
  localparam int MOMENT_MS = 500;

  // Settings that steer the filter
  typedef struct packed {
    logic              peak_en;
    logic              auto_en;
    logic              delay_en;
    logic              hold_en;
    logic [31:0]       decay_cdeg;
    logic [TEMP_W-1:0] thresh;
    logic [15:0]       delay_ms;
  } settings_t;

  // Observed state
  typedef struct packed {
    logic below;
    logic peaking;
    logic delaying;
    logic frozen;
    logic contact_off;
  } status_t;
endpackage

// >>> rtl/peak_core.sv
// Peak detector core: hold, decay, reset and start delay
`timescale 1ns/100ps
`default_nettype none
module peak_core #(
  parameter int TICK_CYCLES = peak_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                      i_clock,
  input  wire logic                      i_nrst,
  // Settings and commands
  input  wire peak_pkg::settings_t       i_set,
  input  wire logic                      i_peak_off,
  input  wire logic                      i_reset_pulse,
  // Filtered temperature in
  input  wire logic [peak_pkg::TEMP_W-1:0] i_temp,
  // Result
  output logic [peak_pkg::TEMP_W-1:0]    o_value,
  output logic                           o_below,
  output logic                           o_peaking,
  output logic                           o_delaying
);
  typedef enum {S_DIRECT, S_DELAY, S_PEAK} state_t;
  state_t state;
  logic [31:0] tick_cnt;
  logic        tick;
  logic [31:0] delay_cnt;
  logic [31:0] frac_acc;
  logic [peak_pkg::TEMP_W-1:0] held;
  logic [peak_pkg::TEMP_W-1:0] step;
  logic        below;
  logic        gate_auto;
  logic [31:0] delay_ticks;

  assign below = i_set.auto_en && (i_temp < i_set.thresh);
  assign gate_auto = i_set.auto_en;
  assign delay_ticks = 32'(i_set.delay_ms) * 32'(peak_pkg::TICKS_PER_MS);

  // Sample tick
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
      tick     <= 1'b0;
    end
  end

  // Phase: direct, delaying, peaking
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state     <= S_DIRECT;
      delay_cnt <= '0;
    end else if (!i_set.peak_en || i_peak_off) begin
      state     <= S_DIRECT;
      delay_cnt <= '0;
    end else if (!gate_auto) begin
      state     <= S_PEAK;
      delay_cnt <= '0;
    end else begin
      unique case (state)
        S_DIRECT: if (!below) begin
          state     <= (i_set.delay_en && delay_ticks != 0) ? S_DELAY : S_PEAK;
          delay_cnt <= '0;
        end
        S_DELAY: begin
          if (below) state <= S_DIRECT;
          else if (tick) begin
            if (delay_cnt + 32'h1 >= delay_ticks) state <= S_PEAK;
            delay_cnt <= delay_cnt + 32'h1;
          end
        end
        S_PEAK: if (below) state <= S_DIRECT;
      endcase
    end
  end

  // Decay step per tick, fraction carried between ticks
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      frac_acc <= '0;
      step     <= '0;
    end else if (tick) begin
      // Step in 1/256 degree units: rate*256/(100*ticks_per_s)
      frac_acc <= (frac_acc + (i_set.decay_cdeg << peak_pkg::FRAC_W))
                  % 32'(100 * peak_pkg::TICKS_PER_S);
      step <= peak_pkg::TEMP_W'((frac_acc + (i_set.decay_cdeg << peak_pkg::FRAC_W))
                  / 32'(100 * peak_pkg::TICKS_PER_S));
    end
  end

  // Held peak
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) held <= '0;
    else if (state != S_PEAK || i_reset_pulse || below) held <= i_temp;
    else if (i_temp > held) held <= i_temp;
    else if (tick) held <= (held - i_temp > step) ? held - step : i_temp;
  end

  // Output register: peaked value or direct value
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_value    <= '0;
      o_below    <= 1'b0;
      o_peaking  <= 1'b0;
      o_delaying <= 1'b0;
    end else begin
      o_value    <= (state == S_PEAK && !below) ? held : i_temp;
      o_below    <= below;
      o_peaking  <= state == S_PEAK;
      o_delaying <= state == S_DELAY;
    end
  end

  a_off_direct: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (!i_set.peak_en) ##1 (!i_set.peak_en) |=> (o_value == $past(i_temp)))
    else $error("direct value not passed with peaking off");
  a_peak_no_drop: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (state == S_PEAK && !below && !i_reset_pulse && !tick && i_temp <= held
     && $past(state) == S_PEAK) |=> (held == $past(held)))
    else $error("held peak changed without tick");
  // Compared with the input of the deciding cycle; a new input may land with the update
  a_peak_ge_in: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (state == S_PEAK && !i_reset_pulse && !below && $stable(i_temp))
      |=> held >= $past(i_temp))
    else $error("held peak below input");
  a_reset_track: assert property (@(posedge i_clock) disable iff (!i_nrst)
    i_reset_pulse |=> held == $past(i_temp))
    else $error("reset did not discard peak");
  a_below_direct: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (below && i_set.peak_en) |=> state == S_DIRECT)
    else $error("below threshold without reset");
  // Settings judged as they stood at the deciding edge, not one cycle later
  a_delay_first: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (state == S_DIRECT && $past(state) == S_DIRECT) ##1 (state == S_PEAK)
      |-> !$past(i_set.delay_en && gate_auto && delay_ticks != 0))
    else $error("peaking started without delay");
endmodule
`default_nettype wire

// >>> rtl/peak_picker_track_hold.sv
// Peak picker with track and hold, Wishbone settings
`timescale 1ns/100ps
`default_nettype none
module peak_picker_track_hold #(
  parameter int TICK_CYCLES = peak_pkg::TICK_CYCLES,
  parameter int MOMENT_CYCLES = peak_pkg::MOMENT_MS * (peak_pkg::CLOCK_HZ / 1000)
) (
  // Clock and reset
  input  wire logic                        i_clock,
  input  wire logic                        i_nrst,
  // Wishbone slave
  input  wire logic                        i_wb_cyc,
  input  wire logic                        i_wb_stb,
  input  wire logic                        i_wb_we,
  input  wire logic [7:0]                  i_wb_adr,
  input  wire logic [3:0]                  i_wb_sel,
  input  wire logic [31:0]                 i_wb_dat,
  output logic [31:0]                      o_wb_dat,
  output logic                             o_wb_ack,
  // Contacts, high while closed
  input  wire logic                        i_reset_contact,
  input  wire logic                        i_hold_contact,
  // Response-time filtered temperature
  input  wire logic [peak_pkg::TEMP_W-1:0] i_temp,
  // Result to display, analog and controller
  output logic [peak_pkg::TEMP_W-1:0]      o_temp,
  output logic [peak_pkg::TEMP_W-1:0]      o_peaked,
  output logic [peak_pkg::RESP_W-1:0]      o_resp_ms
);
  localparam int RESP_W = peak_pkg::RESP_W;
  peak_pkg::settings_t set;
  peak_pkg::status_t   stat;
  logic [31:0] ctrl;
  logic [31:0] decay_reg;
  logic [31:0] thresh_reg;
  logic [31:0] delay_reg;
  logic [31:0] resp_reg;
  logic        wr;
  logic        rd_hit;
  logic        sw_reset;
  logic [31:0] contact_cnt;
  logic        contact_prev;
  logic        contact_off;
  logic        contact_pulse;
  logic        reset_pulse;
  logic        frozen;
  logic [peak_pkg::TEMP_W-1:0] core_val;
  logic        core_below;
  logic        core_peaking;
  logic        core_delaying;

  // Byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  // Address decode, used by the read path only; writes decode through their own case
  function automatic logic mapped(input logic [7:0] a);
    return a == peak_pkg::ADDR_CTRL || a == peak_pkg::ADDR_DECAY
        || a == peak_pkg::ADDR_THRESH || a == peak_pkg::ADDR_DELAY
        || a == peak_pkg::ADDR_RESP || a == peak_pkg::ADDR_STATUS
        || a == peak_pkg::ADDR_PEAK || a == peak_pkg::ADDR_OUT;
  endfunction

  assign wr = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack;
  assign rd_hit = mapped(i_wb_adr);

  // Ack one cycle after strobe, dropped the next cycle
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) o_wb_ack <= 1'b0;
    else o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
  end

  // Settings registers; unmapped writes are ignored
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl       <= peak_pkg::CTRL_RST_VAL;
      decay_reg  <= peak_pkg::DECAY_RST_VAL;
      thresh_reg <= peak_pkg::THRESH_RST_VAL;
      delay_reg  <= peak_pkg::DELAY_RST_VAL;
      resp_reg   <= peak_pkg::RESP_RST_VAL;
    end else if (wr) begin
      unique case (i_wb_adr)
        peak_pkg::ADDR_CTRL:   ctrl <= merge(ctrl, i_wb_dat, i_wb_sel) &
                                       ~(32'h1 << peak_pkg::CTRL_RESET);
        peak_pkg::ADDR_DECAY:  decay_reg <= merge(decay_reg, i_wb_dat, i_wb_sel);
        peak_pkg::ADDR_THRESH: thresh_reg <= merge(thresh_reg, i_wb_dat, i_wb_sel);
        peak_pkg::ADDR_DELAY:  delay_reg <= merge(delay_reg, i_wb_dat, i_wb_sel);
        peak_pkg::ADDR_RESP:   resp_reg <= merge(resp_reg, i_wb_dat, i_wb_sel);
        default: ;
      endcase
    end
  end

  // Self-clearing reset command bit
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) sw_reset <= 1'b0;
    else sw_reset <= wr && i_wb_adr == peak_pkg::ADDR_CTRL && i_wb_sel[0]
                     && i_wb_dat[peak_pkg::CTRL_RESET];
  end

  // Clamp settings to documented ranges
  always_comb begin
    set.peak_en  = ctrl[peak_pkg::CTRL_PEAK_EN];
    set.auto_en  = ctrl[peak_pkg::CTRL_AUTO_EN];
    set.delay_en = ctrl[peak_pkg::CTRL_DELAY_EN];
    set.hold_en  = ctrl[peak_pkg::CTRL_HOLD_EN];
    set.thresh   = thresh_reg[peak_pkg::TEMP_W-1:0];
    if (decay_reg < 32'(peak_pkg::DECAY_MIN_CDEG)) set.decay_cdeg = 32'(peak_pkg::DECAY_MIN_CDEG);
    else if (decay_reg > 32'(peak_pkg::DECAY_MAX_CDEG)) set.decay_cdeg = 32'(peak_pkg::DECAY_MAX_CDEG);
    else set.decay_cdeg = decay_reg;
    if (delay_reg > 32'(peak_pkg::DELAY_MAX_MS)) set.delay_ms = 16'(peak_pkg::DELAY_MAX_MS);
    else set.delay_ms = delay_reg[15:0];
  end

  // Reset contact: long closure disables peaking, short closure resets
  // A closure counts as momentary only if it opens before the limit,
  // so a held contact never fires a spurious reset on release.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      contact_cnt   <= '0;
      contact_prev  <= 1'b0;
      contact_off   <= 1'b0;
      contact_pulse <= 1'b0;
    end else begin
      contact_prev  <= i_reset_contact;
      contact_pulse <= contact_prev && !i_reset_contact
                       && contact_cnt < 32'(MOMENT_CYCLES);
      if (!i_reset_contact) begin
        contact_cnt <= '0;
        contact_off <= 1'b0;
      end else if (contact_cnt >= 32'(MOMENT_CYCLES)) begin
        contact_off <= set.peak_en;
      end else begin
        contact_cnt <= contact_cnt + 32'h1;
      end
    end
  end

  assign reset_pulse = sw_reset | contact_pulse;

  peak_core #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_core (
    .i_clock       (i_clock),
    .i_nrst        (i_nrst),
    .i_set         (set),
    .i_peak_off    (contact_off),
    .i_reset_pulse (reset_pulse),
    .i_temp        (i_temp),
    .o_value       (core_val),
    .o_below       (core_below),
    .o_peaking     (core_peaking),
    .o_delaying    (core_delaying)
  );

  assign frozen = set.hold_en && i_hold_contact;

  // Track and hold on the peaked value; no decay while frozen
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) o_temp <= '0;
    else if (!frozen) o_temp <= core_val;
  end

  // Peaked value straight to the controller path
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) o_peaked <= '0;
    else o_peaked <= core_val;
  end

  // Response time setting held for the upstream filter
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) o_resp_ms <= '0;
    else if (resp_reg < 32'(peak_pkg::RESP_MIN_MS)) o_resp_ms <= RESP_W'(peak_pkg::RESP_MIN_MS);
    else if (resp_reg > 32'(peak_pkg::RESP_MAX_MS)) o_resp_ms <= RESP_W'(peak_pkg::RESP_MAX_MS);
    else o_resp_ms <= resp_reg[peak_pkg::RESP_W-1:0];
  end

  always_comb begin
    stat.below       = core_below;
    stat.peaking     = core_peaking;
    stat.delaying    = core_delaying;
    stat.frozen      = frozen;
    stat.contact_off = contact_off;
  end

  // Read data registered with the ack; unmapped reads give zero
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) o_wb_dat <= '0;
    else if (i_wb_cyc && i_wb_stb && !o_wb_ack) begin
      if (!rd_hit) o_wb_dat <= '0;
      else begin
        unique case (i_wb_adr)
          peak_pkg::ADDR_CTRL:   o_wb_dat <= ctrl;
          peak_pkg::ADDR_DECAY:  o_wb_dat <= decay_reg;
          peak_pkg::ADDR_THRESH: o_wb_dat <= thresh_reg;
          peak_pkg::ADDR_DELAY:  o_wb_dat <= delay_reg;
          peak_pkg::ADDR_RESP:   o_wb_dat <= resp_reg;
          peak_pkg::ADDR_STATUS: o_wb_dat <= 32'(stat);
          peak_pkg::ADDR_PEAK:   o_wb_dat <= 32'(core_val);
          default:               o_wb_dat <= 32'(o_temp);
        endcase
      end
    end
  end

  a_hold_frozen: assert property (@(posedge i_clock) disable iff (!i_nrst)
    frozen ##1 frozen |-> $stable(o_temp))
    else $error("held output moved while frozen");
  a_track_open: assert property (@(posedge i_clock) disable iff (!i_nrst)
    !frozen |=> o_temp == $past(core_val))
    else $error("output not tracking with contact open");
  a_hold_gated: assert property (@(posedge i_clock) disable iff (!i_nrst)
    (!set.hold_en && i_hold_contact) |=> o_temp == $past(core_val))
    else $error("hold honoured while disabled");
  a_contact_off: assert property (@(posedge i_clock) disable iff (!i_nrst)
    !i_reset_contact |=> !contact_off)
    else $error("peaking not restored on contact open");
  a_wb_ack_once: assert property (@(posedge i_clock) disable iff (!i_nrst)
    o_wb_ack |=> !o_wb_ack)
    else $error("ack held two cycles");
endmodule
`default_nettype wire

// >>> sim/contact_model.sv
// Far-side model: reset and track-and-hold contact switches
`timescale 1ns/100ps
`default_nettype none
module contact_model (
  // Clock used to pace switch changes
  input  wire logic i_clock,
  // Contact levels, high while closed
  output logic      o_reset_contact,
  output logic      o_hold_contact
);
  // Both switches rest open, as a normally open contact does
  initial begin
    o_reset_contact = 1'b0;
    o_hold_contact  = 1'b0;
  end

  // Short closure, well under the momentary limit
  task automatic pulse_reset(input int cycles);
    @(posedge i_clock);
    o_reset_contact <= 1'b1;
    repeat (cycles) @(posedge i_clock);
    o_reset_contact <= 1'b0;
  endtask

  // Closure held by the caller; long closures switch peaking off
  task automatic set_reset(input logic closed);
    @(posedge i_clock);
    o_reset_contact <= closed;
  endtask

  // Hold switch, open tracks and closed freezes
  task automatic set_hold(input logic closed);
    @(posedge i_clock);
    o_hold_contact <= closed;
  endtask
endmodule
`default_nettype wire

// >>> sim/peak_picker_track_hold_test.sv
// Self-checking bench for the peak picker with track and hold
`timescale 1ns/100ps
`default_nettype none
module peak_picker_track_hold_test;
  // Bus, contacts, temperature and result
  logic        i_clock, i_nrst, cyc, stb, we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, o_wb_dat;
  logic        o_wb_ack, reset_contact, hold_contact;
  logic [23:0] temp, o_temp, o_peaked, snap;
  logic [15:0] o_resp_ms;
  int          err_count, checked;

  // Short tick and momentary limit keep the run brief
  peak_picker_track_hold #(.TICK_CYCLES(10), .MOMENT_CYCLES(20)) dut (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .i_reset_contact(reset_contact), .i_hold_contact(hold_contact),
    .i_temp(temp), .o_temp(o_temp), .o_peaked(o_peaked), .o_resp_ms(o_resp_ms));

  contact_model cm (.i_clock(i_clock), .o_reset_contact(reset_contact),
    .o_hold_contact(hold_contact));

  // 10 MHz clock
  always #50 i_clock = ~i_clock;

  task automatic stop_test();
    if (err_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge i_clock);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      stop_test();
    end
    rdat = o_wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hF);
  endtask

  // Write through chosen byte lanes only
  task automatic wrs(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    wb(1'b1, a, d, s);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h00000000, 4'hF);
    check(rdat, exp);
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  task automatic set_temp(input logic [23:0] v, input int n);
    @(posedge i_clock);
    temp <= v;
    waitc(n);
  endtask

  // Status bit as a word, for the shared compare
  task automatic status_bit(input int b, input logic exp);
    wb(1'b0, peak_pkg::ADDR_STATUS, 32'h00000000, 4'hF);
    check(32'(rdat[b]), 32'(exp));
  endtask

  // Watchdog against a hang anywhere in the sequence
  initial begin
    waitc(100000);
    err_count++;
    stop_test();
  end

  initial begin
    i_clock = 1'b0; i_nrst = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
    adr = 8'h00; sel = 4'h0; wdat = 32'h00000000; temp = 24'h000000;
    err_count = 0; checked = 0;
    waitc(5);
    i_nrst <= 1'b1;
    // Reset values, unmapped place and clamps
    rd(peak_pkg::ADDR_CTRL, peak_pkg::CTRL_RST_VAL);
    rd(peak_pkg::ADDR_DECAY, peak_pkg::DECAY_RST_VAL);
    rd(peak_pkg::ADDR_THRESH, peak_pkg::THRESH_RST_VAL);
    rd(peak_pkg::ADDR_DELAY, peak_pkg::DELAY_RST_VAL);
    rd(peak_pkg::ADDR_RESP, peak_pkg::RESP_RST_VAL);
    wr(8'h20, 32'hFFFFFFFF);
    rd(8'h20, 32'h00000000);
    wr(peak_pkg::ADDR_RESP, 32'h00000005);
    waitc(2);
    check(32'(o_resp_ms), 32'h0000000A);
    wr(peak_pkg::ADDR_RESP, 32'h00011170);
    waitc(2);
    check(32'(o_resp_ms), 32'h0000EA60);
    wr(peak_pkg::ADDR_DECAY, 32'h00000000);
    // Readback is the raw word; the clamp acts on the rate itself
    rd(peak_pkg::ADDR_DECAY, 32'h00000000);
    wr(peak_pkg::ADDR_DECAY, 32'h00009C40);
    rd(peak_pkg::ADDR_DECAY, 32'h00009C40);
    wr(peak_pkg::ADDR_DECAY, 32'h00000001);
    // Peaking off passes the input straight through
    set_temp(24'h001000, 4);
    check(32'(o_temp), 32'h00001000);
    // Peak follows a rise and keeps it
    wr(peak_pkg::ADDR_CTRL, 32'h00000001);
    set_temp(24'h001800, 4);
    set_temp(24'h000800, 30);
    check(32'(o_peaked), 32'h00001800);
    check(32'(o_temp), 32'h00001800);
    // Menu reset, bit reads back clear
    wr(peak_pkg::ADDR_CTRL, 32'h00000011);
    waitc(4);
    check(32'(o_peaked), 32'h00000800);
    rd(peak_pkg::ADDR_CTRL, 32'h00000001);
    // Momentary contact closure resets the peak
    set_temp(24'h001800, 4);
    set_temp(24'h000800, 4);
    cm.pulse_reset(5);
    waitc(6);
    check(32'(o_peaked), 32'h00000800);
    // Long closure turns peaking off until opened
    set_temp(24'h001800, 4);
    cm.set_reset(1'b1);
    waitc(40);
    set_temp(24'h000400, 4);
    check(32'(o_peaked), 32'h00000400);
    status_bit(0, 1'b1);
    cm.set_reset(1'b0);
    waitc(4);
    set_temp(24'h001800, 4);
    set_temp(24'h000800, 10);
    check(32'(o_peaked), 32'h00001800);
    // Fastest decay, then floor at the input
    // Above the top rate, so the clamp leaves 300 deg/s: 76.8 units a tick,
    // eight or nine ticks reach the output before the compare
    wr(peak_pkg::ADDR_DECAY, 32'h00009C40);
    waitc(100);
    check(32'(o_peaked > 24'h001540 && o_peaked < 24'h0015A8), 32'h1);
    waitc(3000);
    check(32'(o_peaked), 32'h00000800);
    // Hold contact ignored while hold is disabled, then freezes the output once hold is enabled
    wr(peak_pkg::ADDR_DECAY, 32'h00000001);
    cm.set_hold(1'b1);
    set_temp(24'h001000, 10);
    check(32'(o_temp), 32'h00001000);
    wr(peak_pkg::ADDR_CTRL, 32'h00000009);
    waitc(4);
    set_temp(24'h002000, 10);
    check(32'(o_temp), 32'h00001000);
    check(32'(o_peaked), 32'h00002000);
    status_bit(1, 1'b1);
    rd(peak_pkg::ADDR_OUT, 32'h00001000);
    rd(peak_pkg::ADDR_PEAK, 32'h00002000);
    wr(peak_pkg::ADDR_DECAY, 32'h00007530);
    set_temp(24'h000800, 200);
    check(32'(o_temp), 32'h00001000);
    check(32'(o_peaked < 24'h002000), 32'h1);
    wr(peak_pkg::ADDR_DECAY, 32'h00000001);
    cm.set_hold(1'b0);
    waitc(6);
    snap = o_peaked;
    check(32'(o_temp), 32'(snap));
    // Automatic reset below the threshold
    // Only lane 1 lands; the other lanes keep their reset zeros
    wrs(peak_pkg::ADDR_THRESH, 32'hFFFF10FF, 4'h2);
    rd(peak_pkg::ADDR_THRESH, 32'h00001000);
    wr(peak_pkg::ADDR_CTRL, 32'h00000003);
    set_temp(24'h000800, 6);
    check(32'(o_temp), 32'h00000800);
    status_bit(4, 1'b1);
    set_temp(24'h002000, 6);
    set_temp(24'h001800, 10);
    check(32'(o_peaked), 32'h00002000);
    set_temp(24'h000C00, 6);
    check(32'(o_peaked), 32'h00000C00);
    // Start delay after a target edge, repeating per target
    wr(peak_pkg::ADDR_DELAY, 32'h00004E20);
    rd(peak_pkg::ADDR_DELAY, 32'h00004E20);
    wr(peak_pkg::ADDR_DELAY, 32'h00000005);
    wr(peak_pkg::ADDR_CTRL, 32'h00000007);
    set_temp(24'h002000, 6);
    status_bit(2, 1'b1);
    set_temp(24'h001800, 6);
    check(32'(o_peaked), 32'h00001800);
    waitc(80);
    set_temp(24'h003000, 6);
    set_temp(24'h002800, 10);
    check(32'(o_peaked), 32'h00003000);
    set_temp(24'h000800, 6);
    check(32'(o_peaked), 32'h00000800);
    set_temp(24'h002000, 6);
    set_temp(24'h001800, 6);
    check(32'(o_peaked), 32'h00001800);
    // Delay has no effect without automatic reset
    wr(peak_pkg::ADDR_CTRL, 32'h00000005);
    set_temp(24'h002000, 6);
    set_temp(24'h001800, 10);
    check(32'(o_peaked), 32'h00002000);
    stop_test();
  end
endmodule
`default_nettype wire
